// File: csd_defines.svh
// constants of the core state block: rule notes, offsets, codes, resets
//
// Functional notes
// - call or interrupt entry pushes pc plus one onto a 16 x 14 stack.
// - plain and interrupt returns pop the stack top into pc; skipping return loads top plus one.
// - stack nests 16 deep; entries readable and writable as I/O resource.
// - 4-bit ALU adds, subtracts, logic, compares, tests directly on memory.
// - program memory 8192 x 16, 0000H-1FFFH; jumps and calls reach all.
// - direct lookup reads page 0 word into the data register.
// - pointer lookup reads pages 0 to 3 into the data register.
// - rows 10H-1FH reachable only indirectly through the row select.
// - locations 00H-0FH are general registers chosen by column address.
// - wide load and save address 256 words, rows 00H-0FH, no row select.
// - 5-bit row select set by immediate op, used only by row moves.
// - data register is a port; first read moves one nibble to memory.
// - 14-bit pointer addresses pointer lookup and then increments by one.
// - move copies data register into pointer; pointer is I/O accessible.
// - carry set on carry or borrow; only arithmetic, compares, shifts.
// - interrupt entry saves 26-bit context in 4-level stack; return restores.
// - skip condition met advances pc by two; two skip-capable ops.
// - 33 single-word instructions identified by a 6-bit code.
// - pc is 14-bit up-counter cleared by reset, plus one per op.
// - interrupt loads vector 0001H, 0002H or 0003H by source group.
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CSD_REG_OP       8'h00
`define CSD_REG_PC       8'h04
`define CSD_REG_STATUS   8'h08
`define CSD_REG_DATA     8'h0C
`define CSD_REG_PTR      8'h10
`define CSD_REG_SP       8'h14
`define CSD_REG_CRS_IDX  8'h18
`define CSD_REG_CRS_ENT  8'h1C
`define CSD_REG_PM_ADDR  8'h20
`define CSD_REG_PM_DATA  8'h24
`define CSD_REG_DM_ADDR  8'h28
`define CSD_REG_DM_DATA  8'h2C
`define CSD_REG_ROW      8'h30

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define CSD_ST_CARRY     0
`define CSD_ST_SKIP      1
`define CSD_ST_DSEL_LO   8
`define CSD_ST_ISP_LO    16

// ----------------------------------------------------------------------
// operation codes (6-bit)
// ----------------------------------------------------------------------
`define CSD_OP_ADD_IMM   6'h00
`define CSD_OP_ADDC_IMM  6'h01
`define CSD_OP_SUB_IMM   6'h02
`define CSD_OP_SUBB_IMM  6'h03
`define CSD_OP_OR_IMM    6'h04
`define CSD_OP_AND_IMM   6'h05
`define CSD_OP_XOR_IMM   6'h06
`define CSD_OP_MOV_IMM   6'h07
`define CSD_OP_ADD_REG   6'h08
`define CSD_OP_ADDC_REG  6'h09
`define CSD_OP_SUB_REG   6'h0A
`define CSD_OP_SUBB_REG  6'h0B
`define CSD_OP_CMP_LESS  6'h0C
`define CSD_OP_CMP_LESSC 6'h0D
`define CSD_OP_ROW_DEST  6'h0E
`define CSD_OP_ROW_SRC   6'h0F
`define CSD_OP_LOAD_WIDE 6'h10
`define CSD_OP_SAVE_WIDE 6'h11
`define CSD_OP_SHIFT_RC  6'h12
`define CSD_OP_ROT_RC    6'h13
`define CSD_OP_TEST_ALL  6'h14
`define CSD_OP_SKIP_EQ   6'h15
`define CSD_OP_JUMP      6'h16
`define CSD_OP_CALL      6'h17
`define CSD_OP_RET       6'h18
`define CSD_OP_RET_SKIP  6'h19
`define CSD_OP_RET_INT   6'h1A
`define CSD_OP_INT_ENTRY 6'h1B
`define CSD_OP_LOOK_DIR  6'h1C
`define CSD_OP_LOOK_IND  6'h1D
`define CSD_OP_PTR_WORD  6'h1E
`define CSD_OP_ROW_SET   6'h1F
`define CSD_OP_PORT_RD1  6'h20

// ----------------------------------------------------------------------
// vectors, limits and reset values
// ----------------------------------------------------------------------
`define CSD_VEC_GRP1     14'h0001
`define CSD_VEC_GRP2     14'h0002
`define CSD_VEC_GRP3     14'h0003
`define CSD_PM_TOP_MASK  14'h1FFF
`define CSD_PC_RST       14'h0000

`endif

// File: csd_pkg.sv
// types shared by the core state block
package csd_pkg;

  // operation word written to the op register
  typedef struct packed {
    logic [1:0]  rsv;
    logic [13:0] tgt;
    logic [3:0]  c;
    logic [3:0]  dc;
    logic [1:0]  dr;
    logic [5:0]  op;
  } csd_op_t;

  // interrupt context entry, 26 bits
  typedef struct packed {
    logic [4:0]  row;
    logic [3:0]  dsel;
    logic        carry;
    logic [15:0] data;
  } csd_ctx_t;

  // captured bus address phase
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
  } csd_aph_t;

endpackage : csd_pkg

// File: csd_core.sv
// core state block: stacks, alu on memory, lookups, pointer, skip, pc
`timescale 1ns/1ps
`include "csd_defines.svh"

module csd_core
  import csd_pkg::*;
#(
  parameter int CRS_DEPTH = 16,
  parameter int ICS_DEPTH = 4,
  parameter int PM_WORDS  = 8192,
  parameter int DM_WORDS  = 512
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [13:0] pc
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [13:0] crs_mem [CRS_DEPTH];
  csd_ctx_t    ics_mem [ICS_DEPTH];
  logic [15:0] pm_mem  [PM_WORDS];
  logic [3:0]  dm_mem  [DM_WORDS];

  logic [13:0] pc_r, pc_nxt;
  logic        carry_r, carry_nxt;
  logic [4:0]  row_r, row_nxt;
  logic [3:0]  dsel_r, dsel_nxt;
  logic [15:0] data_r, data_nxt;
  logic [13:0] ptr_r, ptr_nxt;
  logic [3:0]  sp_r, sp_nxt;
  logic [1:0]  isp_r, isp_nxt;
  logic [3:0]  crs_idx_r, crs_idx_nxt;
  logic [12:0] pma_r, pma_nxt;
  logic [8:0]  dma_r, dma_nxt;
  logic        skip_r, skip_nxt;
  csd_aph_t    aph_r;
  logic [31:0] hrdata_r;

  logic        crs_we, ics_we, dm_we, skip;
  logic [3:0]  crs_wa;
  logic [13:0] crs_wd;
  logic [1:0]  ics_wa;
  csd_ctx_t    ics_wd;
  logic [8:0]  dm_wa;
  logic [3:0]  dm_wd;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire         accept  = hsel & htrans[1] & hready;
  wire         wr_go   = aph_r.wr;
  wire         op_go   = wr_go & (aph_r.addr == `CSD_REG_OP);
  csd_op_t     opf;
  assign opf = csd_op_t'(hwdata);

  // ----------------------------------------------------------------------
  // operand addressing
  // ----------------------------------------------------------------------
  wire [8:0]  m_addr  = {3'h0, opf.dr, opf.dc};
  wire [8:0]  r_addr  = {5'h00, opf.c};
  wire [8:0]  w_addr  = {1'b0, opf.tgt[3:0], opf.dc};
  wire [3:0]  m_val   = dm_mem[m_addr];
  wire [3:0]  r_val   = dm_mem[r_addr];
  wire [8:0]  g_addr  = {row_r, r_val};
  wire [3:0]  g_val   = dm_mem[g_addr];
  wire [3:0]  w_val   = dm_mem[w_addr];
  wire [13:0] pc_inc1 = pc_r + 14'h0001;
  wire [13:0] pc_inc2 = pc_r + 14'h0002;
  wire [3:0]  sp_dec  = sp_r - 4'h1;
  wire [1:0]  isp_dec = isp_r - 2'h1;
  wire [13:0] crs_top = crs_mem[sp_dec];
  wire [9:0]  dir_a   = {opf.dr, opf.dc, r_val};
  wire [15:0] dir_w   = pm_mem[{3'h0, dir_a}];
  wire [15:0] ind_w   = pm_mem[{1'b0, ptr_r[11:0]}];

  // ----------------------------------------------------------------------
  // alu: operand select, add and subtract with carry or borrow
  // ----------------------------------------------------------------------
  wire        reg_op  = opf.op[3];
  wire [3:0]  alu_a   = reg_op ? r_val : m_val;
  wire [3:0]  alu_b   = reg_op ? m_val : opf.c;
  wire        use_c   = (opf.op == `CSD_OP_ADDC_IMM) |
                        (opf.op == `CSD_OP_ADDC_REG) |
                        (opf.op == `CSD_OP_SUBB_IMM) |
                        (opf.op == `CSD_OP_SUBB_REG) |
                        (opf.op == `CSD_OP_CMP_LESSC);
  wire        cin     = use_c & carry_r;
  wire [4:0]  add_res = {1'b0, alu_a} + {1'b0, alu_b} + {4'h0, cin};
  wire [4:0]  sub_res = {1'b0, alu_a} - {1'b0, alu_b} - {4'h0, cin};
  wire [13:0] vec_pc  = (opf.c[1:0] == 2'h1) ? `CSD_VEC_GRP1 :
                        (opf.c[1:0] == 2'h2) ? `CSD_VEC_GRP2 :
                        `CSD_VEC_GRP3;

  // ----------------------------------------------------------------------
  // next state of the core and of the bus-visible registers
  // ----------------------------------------------------------------------
  always_comb begin
    pc_nxt      = pc_r;
    carry_nxt   = carry_r;
    row_nxt     = row_r;
    dsel_nxt    = dsel_r;
    data_nxt    = data_r;
    ptr_nxt     = ptr_r;
    sp_nxt      = sp_r;
    isp_nxt     = isp_r;
    crs_idx_nxt = crs_idx_r;
    pma_nxt     = pma_r;
    dma_nxt     = dma_r;
    skip_nxt    = skip_r;
    skip        = 1'b0;
    crs_we      = 1'b0;
    crs_wa      = sp_r;
    crs_wd      = pc_inc1;
    ics_we      = 1'b0;
    ics_wa      = isp_r;
    ics_wd      = '{row: row_r, dsel: dsel_r, carry: carry_r, data: data_r};
    dm_we       = 1'b0;
    dm_wa       = m_addr;
    dm_wd       = add_res[3:0];
    if (op_go) begin
      pc_nxt = pc_inc1;
      case (opf.op)
        `CSD_OP_ADD_IMM, `CSD_OP_ADDC_IMM: begin
          dm_we     = 1'b1;
          carry_nxt = add_res[4];
        end
        `CSD_OP_SUB_IMM, `CSD_OP_SUBB_IMM: begin
          dm_we     = 1'b1;
          dm_wd     = sub_res[3:0];
          carry_nxt = sub_res[4];
        end
        `CSD_OP_OR_IMM: begin
          dm_we = 1'b1;
          dm_wd = m_val | opf.c;
        end
        `CSD_OP_AND_IMM: begin
          dm_we = 1'b1;
          dm_wd = m_val & opf.c;
        end
        `CSD_OP_XOR_IMM: begin
          dm_we = 1'b1;
          dm_wd = m_val ^ opf.c;
        end
        `CSD_OP_MOV_IMM: begin
          dm_we = 1'b1;
          dm_wd = opf.c;
        end
        `CSD_OP_ADD_REG, `CSD_OP_ADDC_REG: begin
          dm_we     = 1'b1;
          dm_wa     = r_addr;
          carry_nxt = add_res[4];
        end
        `CSD_OP_SUB_REG, `CSD_OP_SUBB_REG: begin
          dm_we     = 1'b1;
          dm_wa     = r_addr;
          dm_wd     = sub_res[3:0];
          carry_nxt = sub_res[4];
        end
        `CSD_OP_CMP_LESS, `CSD_OP_CMP_LESSC: begin
          carry_nxt = sub_res[4];
        end
        `CSD_OP_ROW_DEST: begin
          dm_we = 1'b1;
          dm_wa = g_addr;
          dm_wd = m_val;
        end
        `CSD_OP_ROW_SRC: begin
          dm_we = 1'b1;
          dm_wd = g_val;
        end
        `CSD_OP_LOAD_WIDE: begin
          dm_we = 1'b1;
          dm_wa = r_addr;
          dm_wd = w_val;
        end
        `CSD_OP_SAVE_WIDE: begin
          dm_we = 1'b1;
          dm_wa = w_addr;
          dm_wd = r_val;
        end
        `CSD_OP_SHIFT_RC: begin
          dm_we     = 1'b1;
          dm_wd     = {1'b0, m_val[3:1]};
          carry_nxt = m_val[0];
        end
        `CSD_OP_ROT_RC: begin
          dm_we     = 1'b1;
          dm_wd     = {carry_r, m_val[3:1]};
          carry_nxt = m_val[0];
        end
        `CSD_OP_TEST_ALL: skip = ((m_val & opf.c) == opf.c);
        `CSD_OP_SKIP_EQ:  skip = (m_val == opf.c);
        `CSD_OP_JUMP: pc_nxt = opf.tgt & `CSD_PM_TOP_MASK;
        `CSD_OP_CALL: begin
          crs_we = 1'b1;
          sp_nxt = sp_r + 4'h1;
          pc_nxt = opf.tgt & `CSD_PM_TOP_MASK;
        end
        `CSD_OP_RET: begin
          pc_nxt = crs_top;
          sp_nxt = sp_dec;
        end
        `CSD_OP_RET_SKIP: begin
          pc_nxt = crs_top + 14'h0001;
          sp_nxt = sp_dec;
        end
        `CSD_OP_RET_INT: begin
          pc_nxt    = crs_top;
          sp_nxt    = sp_dec;
          isp_nxt   = isp_dec;
          row_nxt   = ics_mem[isp_dec].row;
          dsel_nxt  = ics_mem[isp_dec].dsel;
          carry_nxt = ics_mem[isp_dec].carry;
          data_nxt  = ics_mem[isp_dec].data;
        end
        `CSD_OP_INT_ENTRY: begin
          crs_we  = 1'b1;
          sp_nxt  = sp_r + 4'h1;
          ics_we  = 1'b1;
          isp_nxt = isp_r + 2'h1;
          pc_nxt  = vec_pc;
        end
        `CSD_OP_LOOK_DIR: data_nxt = dir_w;
        `CSD_OP_LOOK_IND: begin
          data_nxt = ind_w;
          ptr_nxt  = ptr_r + 14'h0001;
        end
        `CSD_OP_PTR_WORD: ptr_nxt = data_r[13:0];
        `CSD_OP_ROW_SET:  row_nxt = opf.tgt[4:0];
        `CSD_OP_PORT_RD1: begin
          dm_we = 1'b1;
          dm_wd = data_r[{opf.c[1:0], 2'b00} +: 4];
        end
        default: ;
      endcase
      if (skip) begin
        pc_nxt = pc_inc2;
      end
      skip_nxt = skip;
    end else if (wr_go) begin
      case (aph_r.addr)
        `CSD_REG_STATUS: begin
          carry_nxt = hwdata[`CSD_ST_CARRY];
          dsel_nxt  = hwdata[`CSD_ST_DSEL_LO +: 4];
        end
        `CSD_REG_PTR:     ptr_nxt = hwdata[13:0];
        `CSD_REG_SP: begin
          sp_nxt  = hwdata[3:0];
          isp_nxt = hwdata[`CSD_ST_ISP_LO +: 2];
        end
        `CSD_REG_CRS_IDX: crs_idx_nxt = hwdata[3:0];
        `CSD_REG_CRS_ENT: begin
          crs_we = 1'b1;
          crs_wa = crs_idx_r;
          crs_wd = hwdata[13:0];
        end
        `CSD_REG_PM_ADDR: pma_nxt = hwdata[12:0];
        `CSD_REG_PM_DATA: pma_nxt = pma_r + 13'h0001;
        `CSD_REG_DM_ADDR: dma_nxt = hwdata[8:0];
        `CSD_REG_DM_DATA: begin
          dm_we = 1'b1;
          dm_wa = dma_r;
          dm_wd = hwdata[3:0];
        end
        `CSD_REG_ROW:     row_nxt = hwdata[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read data select, unmapped reads as zero
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (aph_r.addr)
      `CSD_REG_PC:      rd_mux = {18'h00000, pc_r};
      `CSD_REG_STATUS: begin
        rd_mux[`CSD_ST_CARRY]       = carry_r;
        rd_mux[`CSD_ST_SKIP]        = skip_r;
        rd_mux[`CSD_ST_DSEL_LO +: 4] = dsel_r;
      end
      `CSD_REG_DATA:    rd_mux = {16'h0000, data_r};
      `CSD_REG_PTR:     rd_mux = {18'h00000, ptr_r};
      `CSD_REG_SP: begin
        rd_mux[3:0]                 = sp_r;
        rd_mux[`CSD_ST_ISP_LO +: 2] = isp_r;
      end
      `CSD_REG_CRS_IDX: rd_mux = {28'h0000000, crs_idx_r};
      `CSD_REG_CRS_ENT: rd_mux = {18'h00000, crs_mem[crs_idx_r]};
      `CSD_REG_PM_ADDR: rd_mux = {19'h00000, pma_r};
      `CSD_REG_PM_DATA: rd_mux = {16'h0000, pm_mem[pma_r]};
      `CSD_REG_DM_ADDR: rd_mux = {23'h000000, dma_r};
      `CSD_REG_DM_DATA: rd_mux = {28'h0000000, dm_mem[dma_r]};
      `CSD_REG_ROW:     rd_mux = {27'h0000000, row_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // bus phase tracking, reads take one wait state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      aph_r    <= '0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      aph_r.wr <= accept & hwrite;
      aph_r.rd <= accept & ~hwrite;
      if (accept) begin
        aph_r.addr <= {haddr[7:2], 2'b00};
      end
      if (aph_r.rd) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = ~aph_r.rd;
  assign hresp     = 1'b0;
  assign pc        = pc_r;

  // ----------------------------------------------------------------------
  // core state registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r      <= `CSD_PC_RST;
      carry_r   <= 1'b0;
      row_r     <= 5'h00;
      dsel_r    <= 4'h0;
      data_r    <= 16'h0000;
      ptr_r     <= 14'h0000;
      sp_r      <= 4'h0;
      isp_r     <= 2'h0;
      crs_idx_r <= 4'h0;
      pma_r     <= 13'h0000;
      dma_r     <= 9'h000;
      skip_r    <= 1'b0;
    end else begin
      pc_r      <= pc_nxt;
      carry_r   <= carry_nxt;
      row_r     <= row_nxt;
      dsel_r    <= dsel_nxt;
      data_r    <= data_nxt;
      ptr_r     <= ptr_nxt;
      sp_r      <= sp_nxt;
      isp_r     <= isp_nxt;
      crs_idx_r <= crs_idx_nxt;
      pma_r     <= pma_nxt;
      dma_r     <= dma_nxt;
      skip_r    <= skip_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // memory write ports
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (crs_we) begin
      crs_mem[crs_wa] <= crs_wd;
    end
    if (ics_we) begin
      ics_mem[ics_wa] <= ics_wd;
    end
    if (dm_we) begin
      dm_mem[dm_wa] <= dm_wd;
    end
    if (wr_go && aph_r.addr == `CSD_REG_PM_DATA) begin
      pm_mem[pma_r] <= hwdata[15:0];
    end
  end

endmodule : csd_core

// File: csd_core_assertions.sv
// checker for the bus timing and program counter of the core state block
`timescale 1ns/1ps
`include "csd_defines.svh"

module csd_core_chk
  import csd_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [13:0] pc
);
  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking

  logic        take;
  logic        op_dp_r;
  logic [5:0]  code;
  logic [13:0] vec;

  // transfer taken, op code in the data phase, expected vector
  assign take = hsel & htrans[1] & hready;
  assign code = hwdata[5:0];
  assign vec  = (hwdata[13:12] == 2'd1) ? `CSD_VEC_GRP1 :
                (hwdata[13:12] == 2'd2) ? `CSD_VEC_GRP2 : `CSD_VEC_GRP3;

  // marks the data phase of a write to the op register
  always_ff @(posedge clk) begin
    if (srst) begin
      op_dp_r <= 1'b0;
    end else begin
      op_dp_r <= take & hwrite & (haddr[7:2] == 6'h00);
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  resp_always_okay_a: assert property (disable iff (srst)
    hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (disable iff (srst)
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait cycle");
  write_ready_a: assert property (disable iff (srst)
    take && hwrite |=> hreadyout) else $error("write data phase stalled");
  pc_reset_a: assert property (
    srst |=> pc == `CSD_PC_RST) else $error("pc not cleared by reset");
  pc_hold_a: assert property (disable iff (srst)
    !op_dp_r |=> $stable(pc)) else $error("pc moved without an op");
  pc_step_a: assert property (disable iff (srst)
    op_dp_r && (code < `CSD_OP_TEST_ALL || code > `CSD_OP_PORT_RD1)
    |=> pc == $past(pc) + 14'h0001) else $error("pc did not step by one");
  jump_target_a: assert property (disable iff (srst)
    op_dp_r && (code == `CSD_OP_JUMP || code == `CSD_OP_CALL)
    |=> pc == ($past(hwdata[29:16]) & `CSD_PM_TOP_MASK))
    else $error("jump or call target wrong");
  int_vector_a: assert property (disable iff (srst)
    op_dp_r && code == `CSD_OP_INT_ENTRY |=> pc == $past(vec))
    else $error("interrupt vector wrong");

endmodule : csd_core_chk

bind csd_core csd_core_chk u_chk (
  .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pc(pc)
);

// File: tb_cpu_stack_and_data_addressing.sv
// self-checking bench for the core state block over its register bus
`timescale 1ns/1ps
`include "csd_defines.svh"

module tb_cpu_stack_and_data_addressing;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [13:0] pc;
  logic [31:0] rd_v;
  logic [13:0] p;
  int          fail_count = 0;
  int          samples_checked = 0;
  // alu walk on word 05H: op, immediate, expected word, expected carry
  logic [5:0]  a_op [19] = '{`CSD_OP_ADD_IMM, `CSD_OP_OR_IMM, `CSD_OP_ADD_IMM,
    `CSD_OP_SUB_IMM, `CSD_OP_SHIFT_RC, `CSD_OP_CMP_LESS, `CSD_OP_ROT_RC,
    `CSD_OP_ADDC_IMM, `CSD_OP_SUBB_IMM, `CSD_OP_SUBB_IMM, `CSD_OP_XOR_IMM,
    `CSD_OP_AND_IMM, `CSD_OP_MOV_IMM, `CSD_OP_ADD_REG, `CSD_OP_ADDC_REG,
    `CSD_OP_SUB_IMM, `CSD_OP_SUBB_REG, `CSD_OP_ADD_IMM, `CSD_OP_CMP_LESSC};
  logic [3:0]  a_c  [19] = '{4'h1, 4'h2, 4'h1, 4'h4, 4'h0, 4'h1, 4'h0, 4'h4,
    4'h9, 4'h2, 4'h6, 4'h3, 4'h9, 4'h5, 4'h5, 4'h6, 4'h5, 4'h0, 4'h1};
  logic [3:0]  a_m  [19] = '{4'h0, 4'h2, 4'h3, 4'hF, 4'h7, 4'h7, 4'h3, 4'h8,
    4'hF, 4'hC, 4'hA, 4'h2, 4'h9, 4'h2, 4'h5, 4'hF, 4'hF, 4'hF, 4'hF};
  logic        a_cy [19] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0,
    1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  csd_core dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pc(pc));

  // 8 ns clock
  initial forever #4 clk = ~clk;

  // ----------------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask : bus

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // pc is looked at one edge after the op has landed
  task automatic pcchk(input logic [13:0] e);
    @(posedge clk);
    samples_checked++;
    if (pc !== e) begin
      fail_count++;
      $display("BAD pc expected %h seen %h", e, pc);
    end
  endtask : pcchk

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(n, e, rd_v);
  endtask : rdc

  task automatic ex(input logic [5:0] code, input logic [5:0] m,
                    input logic [3:0] c, input logic [13:0] t);
    bus(`CSD_REG_OP, 1'b1, {2'b00, t, c, m[3:0], m[5:4], code});
  endtask : ex

  task automatic dms(input logic [8:0] a, input logic [3:0] v);
    bus(`CSD_REG_DM_ADDR, 1'b1, {23'h0, a});
    bus(`CSD_REG_DM_DATA, 1'b1, {28'h0, v});
  endtask : dms

  task automatic dmc(input logic [8:0] a, input logic [3:0] e);
    bus(`CSD_REG_DM_ADDR, 1'b1, {23'h0, a});
    rdc("mem", `CSD_REG_DM_DATA, {28'h0, e});
  endtask : dmc

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    pcchk(14'h0000);
    rdc("row", `CSD_REG_ROW, 32'h0);
    rdc("hole", 8'h3C, 32'h0);
    $display("test reset done");
    ex(`CSD_OP_JUMP, 6'h0, 4'h0, 14'h3F00);
    pcchk(14'h1F00);
    ex(`CSD_OP_CALL, 6'h0, 4'h0, 14'h0123);
    pcchk(14'h0123);
    rdc("sp", `CSD_REG_SP, 32'h1);
    bus(`CSD_REG_CRS_IDX, 1'b1, 32'h0);
    rdc("entry", `CSD_REG_CRS_ENT, 32'h1F01);
    bus(`CSD_REG_CRS_ENT, 1'b1, 32'h1ABC);
    ex(`CSD_OP_RET, 6'h0, 4'h0, 14'h0);
    pcchk(14'h1ABC);
    ex(`CSD_OP_CALL, 6'h0, 4'h0, 14'h0200);
    ex(`CSD_OP_RET_SKIP, 6'h0, 4'h0, 14'h0);
    pcchk(14'h1ABE);
    for (int i = 0; i < 17; i++) ex(`CSD_OP_CALL, 6'h0, 4'h0, 14'h0040);
    rdc("sp", `CSD_REG_SP, 32'h1);
    ex(`CSD_OP_RET, 6'h0, 4'h0, 14'h0);
    pcchk(14'h0041);
    $display("test stack done");
    dms(9'h005, 4'hF);
    dms(9'h001, 4'h9);
    for (int i = 0; i < 19; i++) begin
      ex(a_op[i], 6'h05, a_c[i], 14'h0);
      dmc(9'h005, a_m[i]);
      bus(`CSD_REG_STATUS, 1'b0, 32'h0);
      chk("carry", {31'h0, a_cy[i]}, rd_v & 32'h1);
    end
    $display("test alu done");
    ex(`CSD_OP_ROW_SET, 6'h0, 4'h0, 14'h001A);
    dms(9'h003, 4'h7);
    dms(9'h010, 4'h9);
    ex(`CSD_OP_ROW_DEST, 6'h10, 4'h3, 14'h0);
    dmc(9'h1A7, 4'h9);
    ex(`CSD_OP_ROW_SRC, 6'h11, 4'h3, 14'h0);
    dmc(9'h011, 4'h9);
    rdc("row", `CSD_REG_ROW, 32'h1A);
    dms(9'h0E4, 4'h6);
    ex(`CSD_OP_LOAD_WIDE, 6'h04, 4'h2, 14'h000E);
    dmc(9'h002, 4'h6);
    ex(`CSD_OP_SAVE_WIDE, 6'h09, 4'h2, 14'h000F);
    dmc(9'h0F9, 4'h6);
    $display("test memory done");
    bus(`CSD_REG_PM_ADDR, 1'b1, 32'h3FF);
    bus(`CSD_REG_PM_DATA, 1'b1, 32'hBEEF);
    dms(9'h001, 4'hF);
    ex(`CSD_OP_LOOK_DIR, 6'h3F, 4'h1, 14'h0);
    rdc("data", `CSD_REG_DATA, 32'hBEEF);
    bus(`CSD_REG_PM_ADDR, 1'b1, 32'hFFF);
    bus(`CSD_REG_PM_DATA, 1'b1, 32'h1357);
    bus(`CSD_REG_PTR, 1'b1, 32'hFFF);
    ex(`CSD_OP_LOOK_IND, 6'h0, 4'h0, 14'h0);
    rdc("data", `CSD_REG_DATA, 32'h1357);
    rdc("ptr", `CSD_REG_PTR, 32'h1000);
    ex(`CSD_OP_PTR_WORD, 6'h0, 4'h0, 14'h0);
    rdc("ptr", `CSD_REG_PTR, 32'h1357);
    ex(`CSD_OP_PORT_RD1, 6'h20, 4'h2, 14'h0);
    dmc(9'h020, 4'h3);
    $display("test lookup done");
    for (int g = 1; g < 4; g++) begin
      bus(`CSD_REG_STATUS, 1'b1, 32'h0A01);
      bus(`CSD_REG_ROW, 1'b1, 32'h15);
      p = pc;
      ex(`CSD_OP_INT_ENTRY, 6'h0, 4'(g), 14'h0);
      pcchk(14'(g));
      rdc("isp", `CSD_REG_SP, 32'h10001);
      bus(`CSD_REG_STATUS, 1'b1, 32'h0);
      bus(`CSD_REG_ROW, 1'b1, 32'h0);
      ex(`CSD_OP_LOOK_DIR, 6'h3F, 4'h1, 14'h0);
      ex(`CSD_OP_RET_INT, 6'h0, 4'h0, 14'h0);
      pcchk(p + 14'h1);
      bus(`CSD_REG_STATUS, 1'b0, 32'h0);
      chk("context", 32'h0A01, rd_v & 32'h0F01);
      rdc("row", `CSD_REG_ROW, 32'h15);
      rdc("data", `CSD_REG_DATA, 32'h1357);
    end
    $display("test interrupt done");
    dms(9'h007, 4'h5);
    p = pc;
    ex(`CSD_OP_SKIP_EQ, 6'h07, 4'h5, 14'h0);
    pcchk(p + 14'h2);
    ex(`CSD_OP_SKIP_EQ, 6'h07, 4'h4, 14'h0);
    pcchk(p + 14'h3);
    ex(`CSD_OP_TEST_ALL, 6'h07, 4'h4, 14'h0);
    pcchk(p + 14'h5);
    bus(`CSD_REG_STATUS, 1'b0, 32'h0);
    chk("skip", 32'h2, rd_v & 32'h2);
    ex(6'h3F, 6'h07, 4'h0, 14'h0);
    pcchk(p + 14'h6);
    $display("test skip done");
    summarize();
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

endmodule : tb_cpu_stack_and_data_addressing
